// ### hdl/uss_pkg.sv
package uss_pkg;

  // ****************************************
  // register map (index; byte address is four times the index)
  // ****************************************
  localparam logic [5:0] IDX_CTRL = 6'h0d;
  localparam logic [5:0] IDX_STAT = 6'h0e;
  localparam logic [5:0] IDX_DATA = 6'h0f;
  localparam logic [5:0] IDX_RBUF = 6'h10;
  localparam logic [5:0] IDX_CFG = 6'h11;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [5:0] CFG_RST = 6'h00;

  // serial_status bits
  localparam int STAT_START = 7;
  localparam int STAT_WRAP = 6;
  localparam int STAT_STOP = 5;
  // serial_control strobe bits
  localparam int CTRL_SOFT_CLK = 1;
  localparam int CTRL_TOGGLE = 0;

  localparam logic [3:0] CNT_MAX = 4'hf;
  localparam logic [3:0] CNT_ONE = 4'h1;

  localparam logic [1:0] WM_OFF = 2'h0;
  localparam logic [1:0] WM_THREE = 2'h1;
  localparam logic [1:0] WM_TWO = 2'h2;
  localparam logic [1:0] WM_TWO_HOLD = 2'h3;

  localparam logic [1:0] SLEEP_IDLE = 2'h0;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 50;
  // the serial clock may run at most at half the system clock rate
  localparam int SCK_RATE_DIV = 2;
  localparam int SCK_MIN_PERIOD_NS = CLK_PERIOD_NS * SCK_RATE_DIV;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic start_ie;
    logic wrap_ie;
    logic [1:0] wire_sel;
    logic [1:0] clk_src;
  } uss_ctrl_t;

  typedef struct packed {
    logic [1:0] sleep_mode;
    logic clock_port;
    logic clock_out_en;
    logic data_out_en;
    logic global_ie;
  } uss_cfg_t;

endpackage : uss_pkg

// ### hdl/uss_top.sv
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
// Operation
// [R1] serial clock at most half system clock
// [R2] two-wire slave holds clock low until ready
// [R3] external clock: both edges count once
// [R4] counter preset F: next edge sets wrap
// [R5] shift left on selected clock source
// [R6] data write beats same-cycle shift
// [R7] inputs feed shifter even with outputs off
// [R8] serial out from bit 7 via latch
// [R9] latch open half cycle external, always internal
// [R10] transfer end copies shifter to buffer
// [R11] two-wire start condition sets start flag
// [R12] three-wire/off external edge sets start flag
// [R13] flag with enables requests interrupt, even pending
// [R14] start flag write-one clear releases hold
// [R15] counter wrap 15 to 0 sets flag
// [R16] wrap flag write-one clear releases hold
// [R17] start wakes any sleep, wrap idle only
// [R18] stop condition flag, write-one clear, no irq
// [R19] collision bit: bit 7 differs from pin
// [R20] status low nibble is live counter
// [R21] counter counts each selected clock event
// [R22] external source plus soft strobe: toggle clocks
// [R23] two-wire: clock held low after start
// [R24] mode 11: clock held low after wrap
// [R25] strobe bits pulse once, read zero
module uss_top (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic TIMER_ZERO_MATCH,
  input wire logic SERIAL_IN_PIN,
  output logic SERIAL_IN_OUT,
  output logic SERIAL_IN_OE_N,
  output logic DATA_OUT_PIN,
  output logic DATA_OUT_OE_N,
  input wire logic SERIAL_CLOCK_PIN,
  output logic SERIAL_CLOCK_OUT,
  output logic SERIAL_CLOCK_OE_N,
  output logic IRQ_REQ,
  output logic WAKE_REQ
);

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic [5:0] reg_index(input logic [7:0] addr);
    reg_index = addr[7:2];
  endfunction : reg_index

  function automatic logic is_mapped(input logic [7:0] addr);
    logic [5:0] idx;
    idx = addr[7:2];
    is_mapped = (addr[1:0] == 2'h0) &&
                (idx == uss_pkg::IDX_CTRL || idx == uss_pkg::IDX_STAT ||
                 idx == uss_pkg::IDX_DATA || idx == uss_pkg::IDX_RBUF ||
                 idx == uss_pkg::IDX_CFG);
  endfunction : is_mapped

  uss_pkg::uss_ctrl_t ctrl_reg;
  uss_pkg::uss_cfg_t cfg_reg;
  logic soft_sel_reg;
  logic [7:0] data_reg;
  logic [7:0] data_next;
  logic [7:0] rbuf_reg;
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  logic start_flag_reg;
  logic wrap_flag_reg;
  logic stop_flag_reg;
  logic start_hold_reg;
  logic latch_reg;
  logic latch_next;
  logic pready_reg;
  logic [31:0] prdata_reg;
  logic pslverr_reg;
  logic sck_meta_reg;
  logic sck_sync_reg;
  logic sck_last_reg;
  logic sda_meta_reg;
  logic sda_sync_reg;
  logic sda_last_reg;
  logic sda_out_oe_n_reg;
  logic do_oe_n_reg;
  logic sck_out_reg;
  logic sck_oe_n_reg;
  logic irq_reg;
  logic wake_reg;

  logic access;
  logic wr_en;
  logic ctrl_wr;
  logic stat_wr;
  logic data_wr;
  logic cfg_wr;
  logic soft_clk_pulse;
  logic toggle_pulse;
  logic sck_rise;
  logic sck_fall;
  logic two_wire;
  logic ext_src;
  logic shift_evt;
  logic count_evt;
  logic wrap_evt;
  logic start_evt;
  logic stop_evt;
  logic collision;
  logic latch_open;
  logic scl_pull;

  // ****************************************
  // apb slave: zero wait states, pready raised in the first access cycle
  // ****************************************
  assign access = PSEL && PENABLE && pready_reg;
  assign wr_en = access && PWRITE;
  assign ctrl_wr = wr_en && reg_index(PADDR) == uss_pkg::IDX_CTRL;
  assign stat_wr = wr_en && reg_index(PADDR) == uss_pkg::IDX_STAT;
  assign data_wr = wr_en && reg_index(PADDR) == uss_pkg::IDX_DATA;
  assign cfg_wr = wr_en && reg_index(PADDR) == uss_pkg::IDX_CFG;
  // strobes pulse only in the write cycle; the soft clock bit is also kept in soft_sel_reg
  assign soft_clk_pulse = ctrl_wr && PWDATA[uss_pkg::CTRL_SOFT_CLK]; // see [R25]
  assign toggle_pulse = ctrl_wr && PWDATA[uss_pkg::CTRL_TOGGLE]; // see [R25]

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= PSEL && !PENABLE;
      pslverr_reg <= PSEL && !PENABLE && !is_mapped(PADDR);
    end
  end

  // read data is captured in the setup cycle; no read has side effects
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      prdata_reg <= 32'h0;
    end else if (PSEL && !PENABLE && !PWRITE && is_mapped(PADDR)) begin
      unique case (reg_index(PADDR))
        uss_pkg::IDX_CTRL: prdata_reg <= {24'h0, ctrl_reg, 2'h0}; // see [R25]
        uss_pkg::IDX_STAT: prdata_reg <= {24'h0, start_flag_reg, wrap_flag_reg,
                                          stop_flag_reg, collision, cnt_reg}; // see [R20]
        uss_pkg::IDX_DATA: prdata_reg <= {24'h0, data_reg};
        uss_pkg::IDX_RBUF: prdata_reg <= {24'h0, rbuf_reg}; // see [R10]
        default: prdata_reg <= {26'h0, cfg_reg};
      endcase
    end else begin
      prdata_reg <= 32'h0;
    end
  end

  // ****************************************
  // control and configuration
  // ****************************************
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      ctrl_reg <= uss_pkg::uss_ctrl_t'(uss_pkg::CTRL_RST[7:2]);
      soft_sel_reg <= 1'b0;
    end else if (ctrl_wr) begin
      ctrl_reg <= uss_pkg::uss_ctrl_t'(PWDATA[7:2]);
      soft_sel_reg <= PWDATA[uss_pkg::CTRL_SOFT_CLK];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      cfg_reg <= uss_pkg::uss_cfg_t'(uss_pkg::CFG_RST);
    end else if (cfg_wr) begin
      cfg_reg <= uss_pkg::uss_cfg_t'(PWDATA[5:0]);
    end else if (toggle_pulse) begin
      cfg_reg.clock_port <= !cfg_reg.clock_port;
    end
  end

  // ****************************************
  // pin synchronisers and edge detect
  // ****************************************
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      sck_meta_reg <= 1'b1;
      sck_sync_reg <= 1'b1;
      sck_last_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_last_reg <= 1'b1;
    end else begin
      sck_meta_reg <= SERIAL_CLOCK_PIN;
      sck_sync_reg <= sck_meta_reg;
      sck_last_reg <= sck_sync_reg;
      sda_meta_reg <= SERIAL_IN_PIN;
      sda_sync_reg <= sda_meta_reg;
      sda_last_reg <= sda_sync_reg;
    end
  end

  // one edge per system clock at most; faster serial clocks lose edges
  assign sck_rise = sck_sync_reg && !sck_last_reg; // see [R1]
  assign sck_fall = !sck_sync_reg && sck_last_reg; // see [R1]
  assign two_wire = ctrl_reg.wire_sel[1];
  assign ext_src = ctrl_reg.clk_src[1];
  // start: data falls while clock stays high; stop: data rises likewise
  assign start_evt = two_wire ? (sck_sync_reg && sck_last_reg && sda_last_reg && !sda_sync_reg)
                   : (ext_src && !soft_sel_reg && (sck_rise || sck_fall)); // see [R11] [R12]
  assign stop_evt = two_wire && sck_sync_reg && sck_last_reg &&
                    !sda_last_reg && sda_sync_reg; // see [R18]

  // ****************************************
  // clock source selection
  // ****************************************
  // pin inputs are used whatever the wire mode, see [R7]
  always_comb begin
    shift_evt = 1'b0;
    count_evt = 1'b0;
    unique case (ctrl_reg.clk_src)
      2'h0: begin
        shift_evt = soft_clk_pulse; // see [R5]
        count_evt = soft_clk_pulse || toggle_pulse; // see [R21]
      end
      2'h1: begin
        shift_evt = TIMER_ZERO_MATCH; // see [R5]
        count_evt = TIMER_ZERO_MATCH; // see [R21]
      end
      default: begin
        if (soft_sel_reg) begin
          shift_evt = toggle_pulse; // see [R22]
          count_evt = toggle_pulse; // see [R22]
        end else begin
          shift_evt = ctrl_reg.clk_src[0] ? sck_fall : sck_rise; // see [R5]
          count_evt = sck_rise || sck_fall; // see [R3]
        end
      end
    endcase
  end

  // ****************************************
  // shifter, counter and receive buffer
  // ****************************************
  always_comb begin
    if (data_wr) begin
      data_next = PWDATA[7:0]; // see [R6]
    end else if (shift_evt) begin
      data_next = {data_reg[6:0], sda_sync_reg}; // see [R5]
    end else begin
      data_next = data_reg;
    end
  end

  // a status write owns the counter in its cycle, so a wrap then is lost
  assign wrap_evt = count_evt && !stat_wr && cnt_reg == uss_pkg::CNT_MAX; // see [R4] [R15]

  always_comb begin
    if (stat_wr) begin
      cnt_next = PWDATA[3:0]; // see [R20]
    end else if (count_evt) begin
      cnt_next = cnt_reg + uss_pkg::CNT_ONE; // see [R21]
    end else begin
      cnt_next = cnt_reg;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      data_reg <= uss_pkg::DATA_RST;
      cnt_reg <= uss_pkg::STAT_RST[3:0];
    end else begin
      data_reg <= data_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      rbuf_reg <= uss_pkg::DATA_RST;
    end else if (wrap_evt) begin
      rbuf_reg <= data_next; // see [R10]
    end
  end

  // ****************************************
  // flags: a set in the clearing cycle wins
  // ****************************************
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      start_flag_reg <= 1'b0;
      wrap_flag_reg <= 1'b0;
      stop_flag_reg <= 1'b0;
    end else begin
      start_flag_reg <= start_evt ||
        (start_flag_reg && !(stat_wr && PWDATA[uss_pkg::STAT_START])); // see [R14]
      wrap_flag_reg <= wrap_evt ||
        (wrap_flag_reg && !(stat_wr && PWDATA[uss_pkg::STAT_WRAP])); // see [R16]
      stop_flag_reg <= stop_evt ||
        (stop_flag_reg && !(stat_wr && PWDATA[uss_pkg::STAT_STOP])); // see [R18]
    end
  end

  assign collision = data_reg[7] != sda_sync_reg; // see [R19]

  // ****************************************
  // clock hold and output latch
  // ****************************************
  // hold begins at the master's falling clock edge after the start
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      start_hold_reg <= 1'b0;
    end else begin
      start_hold_reg <= two_wire && start_flag_reg &&
                        (start_hold_reg || sck_fall); // see [R23] [R14]
    end
  end

  assign scl_pull = !cfg_reg.clock_port || start_hold_reg ||
    (ctrl_reg.wire_sel == uss_pkg::WM_TWO_HOLD && wrap_flag_reg); // see [R2] [R24] [R16]

  // the open half ends at the sampling edge, so output moves on the other
  assign latch_open = !ext_src || (sck_sync_reg == ctrl_reg.clk_src[0]); // see [R9]
  assign latch_next = latch_open ? data_next[7] : latch_reg; // see [R8] [R9]

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      latch_reg <= 1'b1;
      sda_out_oe_n_reg <= 1'b1;
      do_oe_n_reg <= 1'b1;
      sck_out_reg <= 1'b1;
      sck_oe_n_reg <= 1'b1;
    end else begin
      latch_reg <= latch_next;
      sda_out_oe_n_reg <= !(two_wire && cfg_reg.data_out_en && !latch_next);
      do_oe_n_reg <= !(ctrl_reg.wire_sel == uss_pkg::WM_THREE && cfg_reg.data_out_en);
      sck_out_reg <= two_wire ? 1'b0 : cfg_reg.clock_port;
      unique case (ctrl_reg.wire_sel)
        uss_pkg::WM_OFF: sck_oe_n_reg <= 1'b1;
        uss_pkg::WM_THREE: sck_oe_n_reg <= !cfg_reg.clock_out_en;
        default: sck_oe_n_reg <= !(cfg_reg.clock_out_en && scl_pull); // see [R2] [R23]
      endcase
    end
  end

  // ****************************************
  // interrupt request and wake
  // ****************************************
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      irq_reg <= 1'b0;
      wake_reg <= 1'b0;
    end else begin
      irq_reg <= cfg_reg.global_ie && ((start_flag_reg && ctrl_reg.start_ie) ||
                                       (wrap_flag_reg && ctrl_reg.wrap_ie)); // see [R13]
      wake_reg <= (start_flag_reg && ctrl_reg.start_ie) ||
                  (wrap_flag_reg && ctrl_reg.wrap_ie &&
                   cfg_reg.sleep_mode == uss_pkg::SLEEP_IDLE); // see [R17]
    end
  end

  assign PRDATA = prdata_reg;
  assign PREADY = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign SERIAL_IN_OUT = 1'b0;
  assign SERIAL_IN_OE_N = sda_out_oe_n_reg;
  assign DATA_OUT_PIN = latch_reg;
  assign DATA_OUT_OE_N = do_oe_n_reg;
  assign SERIAL_CLOCK_OUT = sck_out_reg;
  assign SERIAL_CLOCK_OE_N = sck_oe_n_reg;
  assign IRQ_REQ = irq_reg;
  assign WAKE_REQ = wake_reg;

endmodule : uss_top

// ### verif/uss_monitor.sv
`timescale 1ns/1ps
module uss_monitor (
  input wire logic CLOCK,
  input wire logic RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic SERIAL_IN_OE_N,
  input wire logic DATA_OUT_OE_N,
  input wire logic IRQ_REQ,
  input wire logic SERIAL_CLOCK_OE_N
);
  // ****
  // bus and pin relations
  // ****
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);
  logic setup;
  assign setup = PSEL && !PENABLE;
  a_ready_after_setup: assert property (setup |=> PREADY)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  a_rdata_idle_zero: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside access");
  a_rdata_upper_zero: assert property (PRDATA[31:8] == 24'h0)
    else $error("upper read bits set");
  a_err_with_ready: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  a_err_unmapped: assert property (setup && PADDR[7:2] > uss_pkg::IDX_CFG |=> PSLVERR)
    else $error("unmapped access accepted");
  a_err_mapped: assert property (setup && PADDR == {uss_pkg::IDX_STAT, 2'h0} |=> !PSLVERR)
    else $error("mapped access refused");
  a_strobe_read_zero: assert property (
    setup && !PWRITE && PADDR == {uss_pkg::IDX_CTRL, 2'h0} |=> PRDATA[1:0] == 2'h0)
    else $error("strobe bits read back");
  // two-wire data and three-wire data output must never drive at once
  a_one_data_drv: assert property (!(!SERIAL_IN_OE_N && !DATA_OUT_OE_N))
    else $error("two data drivers enabled");
  c_err: cover property (PSLVERR);
  c_irq: cover property ($rose(IRQ_REQ));
  c_hold: cover property ($fell(SERIAL_CLOCK_OE_N));
endmodule : uss_monitor

bind uss_top uss_monitor u_mon (.CLOCK(CLOCK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .SERIAL_IN_OE_N(SERIAL_IN_OE_N), .DATA_OUT_OE_N(DATA_OUT_OE_N), .IRQ_REQ(IRQ_REQ),
  .SERIAL_CLOCK_OE_N(SERIAL_CLOCK_OE_N));

// ### verif/uss_wire_model.sv
`timescale 1ns/1ps
module uss_wire_model (
  input wire logic scl_oe_n,
  input wire logic scl_out,
  input wire logic sda_oe_n,
  input wire logic sda_out,
  output logic scl_line,
  output logic sda_line
);
  // ****
  // open-drain master on pulled-up lines
  // ****
  logic scl_drv = 1'b1;
  logic sda_drv = 1'b1;
  logic stuck = 1'b0;
  assign scl_line = scl_drv & (scl_oe_n | scl_out);
  assign sda_line = sda_drv & (sda_oe_n | sda_out);
  // 200 ns levels: four system clocks each, far inside half rate
  task automatic rise();
    scl_drv = 1'b1;
    // the slave may stretch the low phase, so wait for the line
    for (int n = 0; n < 400 && !scl_line; n++) #50;
    stuck |= !scl_line;
    #200;
  endtask : rise
  // each frame steps off the system clock edge so no pin races a sampling flop
  task automatic pulse();
    #10;
    scl_drv = 1'b0;
    #200;
    rise();
  endtask : pulse
  task automatic start_cond();
    #10;
    sda_drv = 1'b0;
    #200;
    scl_drv = 1'b0;
    #200;
  endtask : start_cond
  // data moves only mid low phase, never beside a clock edge
  task automatic send(input logic [7:0] b);
    #10;
    for (int i = 7; i >= 0; i--) begin
      scl_drv = 1'b0;
      #100;
      sda_drv = b[i];
      #100;
      rise();
    end
    scl_drv = 1'b0;
  endtask : send
  task automatic stop_cond();
    #10;
    #100;
    sda_drv = 1'b0;
    #100;
    rise();
    sda_drv = 1'b1;
    #200;
  endtask : stop_cond
endmodule : uss_wire_model

// ### verif/tb_universal_serial_shift_unit.sv
`timescale 1ns/1ps
module tb_universal_serial_shift_unit;
  logic CLOCK, RESET, PSEL, PENABLE, PWRITE, TIMER_ZERO_MATCH, PREADY, PSLVERR, last_err;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, r;
  logic SERIAL_IN_OUT, SERIAL_IN_OE_N, DATA_OUT_PIN, DATA_OUT_OE_N, scl, sda;
  logic SERIAL_CLOCK_OUT, SERIAL_CLOCK_OE_N, IRQ_REQ, WAKE_REQ;
  int n_mismatch = 0;
  int checks_done = 0;
  uss_top dut (.CLOCK(CLOCK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .TIMER_ZERO_MATCH(TIMER_ZERO_MATCH), .SERIAL_IN_PIN(sda), .SERIAL_IN_OUT(SERIAL_IN_OUT),
    .SERIAL_IN_OE_N(SERIAL_IN_OE_N), .DATA_OUT_PIN(DATA_OUT_PIN), .DATA_OUT_OE_N(DATA_OUT_OE_N),
    .SERIAL_CLOCK_PIN(scl), .SERIAL_CLOCK_OUT(SERIAL_CLOCK_OUT),
    .SERIAL_CLOCK_OE_N(SERIAL_CLOCK_OE_N), .IRQ_REQ(IRQ_REQ), .WAKE_REQ(WAKE_REQ));
  uss_wire_model wm (.scl_oe_n(SERIAL_CLOCK_OE_N), .scl_out(SERIAL_CLOCK_OUT),
    .sda_oe_n(SERIAL_IN_OE_N), .sda_out(SERIAL_IN_OUT), .scl_line(scl), .sda_line(sda));
  // ****
  // bus tasks
  // ****
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // the timer pulse rides the access cycle so it meets the write edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d, input logic t);
    logic ok;
    ok = 1'b0;
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= {a, 2'h0};
    PWDATA <= {24'h0, d};
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    TIMER_ZERO_MATCH <= t;
    for (int n = 0; n < 20 && !ok; n++) begin
      @(posedge CLOCK);
      ok = (PREADY === 1'b1);
    end
    r = PRDATA;
    last_err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    TIMER_ZERO_MATCH <= 1'b0;
    if (!ok) begin
      n_mismatch++;
      final_report();
    end
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 1'b0);
  endtask : wr
  task automatic rc(input logic [5:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 1'b0);
    chk(r, {24'h0, e});
  endtask : rc
  task automatic pin(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask : pin
  initial begin
    CLOCK = 1'b0;
    forever #25 CLOCK = ~CLOCK;
  end
  // ****
  // scenarios
  // ****
  initial begin
    RESET = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    TIMER_ZERO_MATCH = 1'b0;
    repeat (10) @(posedge CLOCK);
    RESET <= 1'b0;
    rc(uss_pkg::IDX_CTRL, 8'h00);
    // the data line idles high against a zero shifter, so collision reads one
    rc(uss_pkg::IDX_STAT, 8'h10);
    rc(uss_pkg::IDX_DATA, 8'h00);
    rc(uss_pkg::IDX_RBUF, 8'h00);
    rc(6'h3f, 8'h00);
    pin(last_err, 1'b1);
    wr(uss_pkg::IDX_CFG, 8'h0f);
    wr(uss_pkg::IDX_DATA, 8'h81);
    wr(uss_pkg::IDX_CTRL, 8'h02);
    rc(uss_pkg::IDX_CTRL, 8'h00);
    rc(uss_pkg::IDX_DATA, 8'h03);
    rc(uss_pkg::IDX_STAT, 8'h11);
    wr(uss_pkg::IDX_CTRL, 8'h01);
    rc(uss_pkg::IDX_STAT, 8'h12);
    wr(uss_pkg::IDX_STAT, 8'h0f);
    wr(uss_pkg::IDX_CTRL, 8'h02);
    rc(uss_pkg::IDX_STAT, 8'h50);
    rc(uss_pkg::IDX_RBUF, 8'h07);
    pin(IRQ_REQ, 1'b0);
    wr(uss_pkg::IDX_CTRL, 8'h40);
    repeat (2) @(posedge CLOCK);
    pin(IRQ_REQ, 1'b1);
    pin(WAKE_REQ, 1'b1);
    wr(uss_pkg::IDX_CFG, 8'h1f);
    repeat (2) @(posedge CLOCK);
    pin(WAKE_REQ, 1'b0);
    wr(uss_pkg::IDX_STAT, 8'h40);
    repeat (2) @(posedge CLOCK);
    pin(IRQ_REQ, 1'b0);
    // three-wire on the timer clock: the output latch stays open
    wr(uss_pkg::IDX_CTRL, 8'h14);
    bus(1'b1, uss_pkg::IDX_DATA, 8'h5a, 1'b1);
    rc(uss_pkg::IDX_DATA, 8'h5a);
    pin(DATA_OUT_PIN, 1'b0);
    pin(DATA_OUT_OE_N, 1'b0);
    pin(SERIAL_CLOCK_OUT, 1'b1);
    @(posedge CLOCK);
    TIMER_ZERO_MATCH <= 1'b1;
    @(posedge CLOCK);
    TIMER_ZERO_MATCH <= 1'b0;
    rc(uss_pkg::IDX_DATA, 8'hb5);
    pin(DATA_OUT_PIN, 1'b1);
    // pin source with the soft strobe kept: the toggle strobe clocks instead
    wr(uss_pkg::IDX_CTRL, 8'h0a);
    wr(uss_pkg::IDX_CTRL, 8'h0b);
    rc(uss_pkg::IDX_DATA, 8'h6b);
    rc(uss_pkg::IDX_STAT, 8'h13);
    // falling-edge source with outputs off: any pin edge sets the start flag
    wr(uss_pkg::IDX_CTRL, 8'h0c);
    wr(uss_pkg::IDX_DATA, 8'h00);
    wr(uss_pkg::IDX_STAT, 8'he0);
    wm.pulse();
    rc(uss_pkg::IDX_STAT, 8'h92);
    rc(uss_pkg::IDX_DATA, 8'h01);
    wr(uss_pkg::IDX_DATA, 8'hff);
    wr(uss_pkg::IDX_CFG, 8'h0f);
    wr(uss_pkg::IDX_STAT, 8'h80);
    wr(uss_pkg::IDX_CTRL, 8'h38);
    wm.start_cond();
    // the master pulls the data line low against a one in bit 7
    rc(uss_pkg::IDX_STAT, 8'h91);
    pin(SERIAL_CLOCK_OE_N, 1'b0);
    fork
      wm.send(8'ha5);
      wr(uss_pkg::IDX_STAT, 8'h80);
    join
    repeat (6) @(posedge CLOCK);
    rc(uss_pkg::IDX_STAT, 8'h40);
    rc(uss_pkg::IDX_DATA, 8'ha5);
    rc(uss_pkg::IDX_RBUF, 8'ha5);
    pin(SERIAL_CLOCK_OE_N, 1'b0);
    pin(SERIAL_IN_OE_N, 1'b1);
    wr(uss_pkg::IDX_STAT, 8'h40);
    repeat (2) @(posedge CLOCK);
    pin(SERIAL_CLOCK_OE_N, 1'b1);
    wm.stop_cond();
    rc(uss_pkg::IDX_STAT, 8'h31);
    wr(uss_pkg::IDX_STAT, 8'h20);
    rc(uss_pkg::IDX_STAT, 8'h10);
    pin(wm.stuck, 1'b0);
    final_report();
  end
endmodule : tb_universal_serial_shift_unit
